// >>> quadrature_encoder_interface.sv
// Function
// - Mode 111 x4 with limit-match reset; 110 x4 with marker reset.
// - Mode 101 x2 with limit-match reset; 100 x2 with marker reset.
// - Modes 000, 011, 010 leave encoder and timer disabled.
// - Mode 001 runs the 16-bit timer/counter instead of decoding.
// - Sixteen-bit position counter counting up or down by direction.
// - Inputs are phase A, phase B and marker pulse.
// - Count error flag bit 15 set on error, only in 110 or 100.
// - Stop-when-idle bit 13 halts the module while chip is idle.
// - Bit 12 reads the marker pin level.
// - Bit 11 reads one for positive direction, zero for negative.
// - Direction bit hardware-owned in encoder modes, software-writable in timer mode.
// - Swap bit 7 exchanges phase A and B before decoding.
// - Bit 6 drives direction status onto the direction pin.
// - Timer prescaler only acts in timer mode.
// - Marker-reset enable only honoured in modes 100 and 110.
// - Direction source select ignored in encoder modes.
// - Programmable digital noise filters on phase and marker inputs.
// - Marker-reset enable bit 2 lets marker pulse clear the counter.
// - Direction source one uses phase B pin, zero uses direction bit.
// - Timer clock from phase A rising edge or internal clock.
// - Prescale codes 00..11 divide by 1, 8, 64, 256.
//
// The register offsets and strobed register access were left to the implementer.
module quadrature_encoder_interface
  import qei_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // Chip state
  input  wire logic        chipIdle,
  // Encoder pins
  input  wire logic        phaseAPin,
  input  wire logic        phaseBPin,
  input  wire logic        markerPin,
  // Direction pin
  output logic             dirPinOut,
  output logic             dirPinOe,
  // Events
  output logic             countErrorPulse
);
  logic [15:0] ctrl_r;
  logic [15:0] posCount_r;
  logic [15:0] countLimit_r;
  logic [7:0]  filtCfg_r;
  logic        countError_r;
  logic        dirStatus_r;
  logic        aPrev_r;
  logic        bPrev_r;
  logic        mPrev_r;
  logic        gatePrev_r;
  logic [7:0]  fdiv_r;
  logic        fTick_r;

  logic [2:0]  modeSelect;
  logic        encMode;
  logic        timerMode;
  logic        running;
  logic        aF;
  logic        bF;
  logic        mF;
  logic        aDec;
  logic        bDec;
  logic        aEdge;
  logic        bEdge;
  logic        step;
  logic        dirUp;
  logic        illegal;
  logic        markerRise;
  logic        markerReset;
  logic        limitMatch;
  logic        timerSrcTick;
  logic        timerTick;
  logic [7:0]  psTerm;
  logic [7:0]  fTerm;
  logic        timerDir;
  logic        ctrlWr;

  assign modeSelect = ctrl_r[MODE_HI:MODE_LO];
  assign encMode    = modeSelect[2];
  assign timerMode  = (modeSelect == MODE_TIMER);
  assign ctrlWr     = regWr && (regAddr == CTRL_IDX);

  // Idle gating
  // halt while idle
  assign running = !(ctrl_r[SIDL_BIT] && chipIdle);

  // Filter sample-rate divider, shared by all three channels
  always_comb
  begin
    case (filtCfg_r[FCK_HI:FCK_LO])
      3'h0:    fTerm = FDIV_1;
      3'h1:    fTerm = FDIV_2;
      3'h2:    fTerm = FDIV_4;
      3'h3:    fTerm = FDIV_16;
      3'h4:    fTerm = FDIV_32;
      3'h5:    fTerm = FDIV_64;
      3'h6:    fTerm = FDIV_128;
      default: fTerm = FDIV_256;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      fdiv_r  <= 8'h00;
      fTick_r <= 1'b0;
    end
    else if (fdiv_r >= fTerm)
    begin
      fdiv_r  <= 8'h00;
      fTick_r <= 1'b1;
    end
    else
    begin
      fdiv_r  <= fdiv_r + 8'h01;
      fTick_r <= 1'b0;
    end
  end

  pin_sync u_syncA
  (
    .mclk     (mclk),
    .srst     (srst),
    .sampleEn (fTick_r),
    .filterOn (filtCfg_r[FEN_BIT]),
    .pinIn    (phaseAPin),
    .levelOut (aF)
  );

  pin_sync u_syncB
  (
    .mclk     (mclk),
    .srst     (srst),
    .sampleEn (fTick_r),
    .filterOn (filtCfg_r[FEN_BIT]),
    .pinIn    (phaseBPin),
    .levelOut (bF)
  );

  pin_sync u_syncM
  (
    .mclk     (mclk),
    .srst     (srst),
    .sampleEn (fTick_r),
    .filterOn (filtCfg_r[FEN_BIT]),
    .pinIn    (markerPin),
    .levelOut (mF)
  );

  assign aDec = ctrl_r[SWAP_BIT] ? bF : aF;
  assign bDec = ctrl_r[SWAP_BIT] ? aF : bF;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aPrev_r    <= 1'b0;
      bPrev_r    <= 1'b0;
      mPrev_r    <= 1'b0;
      gatePrev_r <= 1'b0;
    end
    else
    begin
      aPrev_r    <= aDec;
      bPrev_r    <= bDec;
      mPrev_r    <= mF;
      gatePrev_r <= aF;
    end
  end

  assign aEdge = aDec ^ aPrev_r;
  assign bEdge = bDec ^ bPrev_r;

  assign illegal = aEdge && bEdge;

  // x4 on both phases, x2 on phase A only; direction from phase relation
  always_comb
  begin
    step  = 1'b0;
    dirUp = dirStatus_r;
    if (!illegal)
    begin
      if (aEdge)
      begin
        step  = 1'b1;
        dirUp = (aDec != bDec);
      end
      else if (bEdge && modeSelect[1])
      begin
        step  = 1'b1;
        dirUp = (aDec == bDec);
      end
    end
  end

  assign markerRise = mF && !mPrev_r;
  // marker reset only in 100 and 110
  assign markerReset = markerRise && ctrl_r[MRST_BIT] && !modeSelect[0];
  assign limitMatch  = (posCount_r == countLimit_r);

  assign timerSrcTick = ctrl_r[TCS_BIT] ? (aF && !gatePrev_r) : 1'b1;

  always_comb
  begin
    case (ctrl_r[PS_HI:PS_LO])
      2'h0:    psTerm = PS_DIV1;
      2'h1:    psTerm = PS_DIV8;
      2'h2:    psTerm = PS_DIV64;
      default: psTerm = PS_DIV256;
    endcase
  end

  // prescaler fed only in timer mode
  prescaler u_presc
  (
    .mclk      (mclk),
    .srst      (srst),
    .tickIn    (timerSrcTick && timerMode && running),
    .termCount (psTerm),
    .tickOut   (timerTick)
  );

  assign timerDir = ctrl_r[DSRC_BIT] ? bF : dirStatus_r;

  // x4 modes and their reset sources
  // x2 modes and their reset sources
  always_ff @(posedge mclk)
  begin
    if (srst)
      posCount_r <= 16'h0000;
    else if (regWr && (regAddr == POS_IDX))
      posCount_r <= regWdata;
    else if (running)
    begin
      case (modeSelect)
        MODE_X4LIM, MODE_X2LIM:
        begin
          if (step)
            posCount_r <= (limitMatch && dirUp) ? 16'h0000
                        : (posCount_r == 16'h0000 && !dirUp) ? countLimit_r
                        : dirUp ? posCount_r + 16'h0001 : posCount_r - 16'h0001;
        end
        MODE_X4IDX, MODE_X2IDX:
        begin
          if (markerReset)
            posCount_r <= 16'h0000;
          else if (step)
            posCount_r <= dirUp ? posCount_r + 16'h0001 : posCount_r - 16'h0001;
        end
        MODE_TIMER:
        begin
          // Gated accumulation counts only while phase A is high
          if (timerTick && (!ctrl_r[GATE_BIT] || aF))
          begin
            if (limitMatch && timerDir)
              posCount_r <= 16'h0000;
            else
              posCount_r <= timerDir ? posCount_r + 16'h0001 : posCount_r - 16'h0001;
          end
        end
        default:
          posCount_r <= posCount_r;
      endcase
    end
  end

  // hardware-owned in encoder modes, software in timer mode
  always_ff @(posedge mclk)
  begin
    if (srst)
      dirStatus_r <= 1'b0;
    else if (encMode && running && step)
      dirStatus_r <= dirUp;
    else if (ctrlWr && timerMode)
      dirStatus_r <= regWdata[DIR_BIT];
  end

  // count error flag; set wins over software clear
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      countError_r    <= 1'b0;
      countErrorPulse <= 1'b0;
    end
    else
    begin
      countErrorPulse <= 1'b0;
      if (running && illegal && encMode && !modeSelect[0])
      begin
        countError_r    <= 1'b1;
        countErrorPulse <= 1'b1;
      end
      else if (ctrlWr)
        countError_r <= regWdata[ERR_BIT];
    end
  end

  // Control, limit and filter registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_r       <= CTRL_RESET;
      countLimit_r <= LIMIT_RESET;
      filtCfg_r    <= 8'h00;
    end
    else if (regWr)
    begin
      case (regAddr)
        CTRL_IDX:  ctrl_r <= regWdata & CTRL_WMASK;
        LIMIT_IDX: countLimit_r <= regWdata;
        FILT_IDX:  filtCfg_r <= {regWdata[FEN_BIT:FCK_LO], 4'h0};
        default:   ctrl_r <= ctrl_r;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dirPinOut <= 1'b0;
      dirPinOe  <= 1'b0;
    end
    else
    begin
      dirPinOut <= dirStatus_r;
      dirPinOe  <= ctrl_r[DOUT_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      regRdata <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        CTRL_IDX:
        begin
          regRdata           <= ctrl_r;
          regRdata[ERR_BIT]  <= countError_r;
          regRdata[MARK_BIT] <= mF;
          regRdata[DIR_BIT]  <= dirStatus_r;
        end
        POS_IDX:   regRdata <= posCount_r;
        LIMIT_IDX: regRdata <= countLimit_r;
        FILT_IDX:  regRdata <= {8'h00, filtCfg_r};
        STAT_IDX:  regRdata <= {13'h0000, mF, bF, aF};
        default:   regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end
endmodule

// >>> qei_pkg.sv
package qei_pkg;
  // Register indices on the plain port
  localparam logic [2:0] CTRL_IDX  = 3'h0;
  localparam logic [2:0] POS_IDX   = 3'h1;
  localparam logic [2:0] LIMIT_IDX = 3'h2;
  localparam logic [2:0] FILT_IDX  = 3'h3;
  localparam logic [2:0] STAT_IDX  = 3'h4;

  // Field positions of encoder_control
  localparam int ERR_BIT  = 15;
  localparam int SIDL_BIT = 13;
  localparam int MARK_BIT = 12;
  localparam int DIR_BIT  = 11;
  localparam int MODE_HI  = 10;
  localparam int MODE_LO  = 8;
  localparam int SWAP_BIT = 7;
  localparam int DOUT_BIT = 6;
  localparam int GATE_BIT = 5;
  localparam int PS_HI    = 4;
  localparam int PS_LO    = 3;
  localparam int MRST_BIT = 2;
  localparam int TCS_BIT  = 1;
  localparam int DSRC_BIT = 0;

  // Filter register fields
  localparam int FEN_BIT = 7;
  localparam int FCK_HI  = 6;
  localparam int FCK_LO  = 4;

  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] CTRL_WMASK  = 16'hA7FF;

  localparam logic [2:0] MODE_OFF   = 3'h0;
  localparam logic [2:0] MODE_TIMER = 3'h1;
  localparam logic [2:0] MODE_X2IDX = 3'h4;
  localparam logic [2:0] MODE_X2LIM = 3'h5;
  localparam logic [2:0] MODE_X4IDX = 3'h6;
  localparam logic [2:0] MODE_X4LIM = 3'h7;

  // Prescale terminal counts (divide minus one)
  localparam logic [7:0] PS_DIV1   = 8'h00;
  localparam logic [7:0] PS_DIV8   = 8'h07;
  localparam logic [7:0] PS_DIV64  = 8'h3F;
  localparam logic [7:0] PS_DIV256 = 8'hFF;

  // Filter sample divider terminal counts (divide minus one)
  localparam logic [7:0] FDIV_1   = 8'h00;
  localparam logic [7:0] FDIV_2   = 8'h01;
  localparam logic [7:0] FDIV_4   = 8'h03;
  localparam logic [7:0] FDIV_16  = 8'h0F;
  localparam logic [7:0] FDIV_32  = 8'h1F;
  localparam logic [7:0] FDIV_64  = 8'h3F;
  localparam logic [7:0] FDIV_128 = 8'h7F;
  localparam logic [7:0] FDIV_256 = 8'hFF;

  // Filter: samples that must agree
  localparam logic [1:0] FILT_AGREE = 2'h3;
endpackage

// >>> pin_sync.sv
module pin_sync
  import qei_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Sampling
  input  wire logic sampleEn,
  input  wire logic filterOn,
  input  wire logic pinIn,
  output logic      levelOut
);
  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic       stable_r;
  logic [1:0] agree_r;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change counts once stages two and three agree; filter needs several agreeing samples
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stable_r <= 1'b0;
      agree_r  <= 2'h0;
      levelOut <= 1'b0;
    end
    else
    begin
      if (s2_r == s3_r)
        stable_r <= s2_r;
      if (!filterOn)
      begin
        agree_r  <= 2'h0;
        levelOut <= stable_r;
      end
      else if (sampleEn)
      begin
        if (stable_r == levelOut)
          agree_r <= 2'h0;
        else if (agree_r == FILT_AGREE - 2'h1)
        begin
          agree_r  <= 2'h0;
          levelOut <= stable_r;
        end
        else
          agree_r <= agree_r + 2'h1;
      end
    end
  end
endmodule

// >>> prescaler.sv
module prescaler
  import qei_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Tick in, divided tick out
  input  wire logic       tickIn,
  input  wire logic [7:0] termCount,
  output logic            tickOut
);
  logic [7:0] cnt_r;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cnt_r   <= 8'h00;
      tickOut <= 1'b0;
    end
    else
    begin
      tickOut <= 1'b0;
      if (tickIn)
      begin
        if (cnt_r >= termCount)
        begin
          cnt_r   <= 8'h00;
          tickOut <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule

// >>> qei_asserts.sv
module qei_asserts
  import qei_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Register port
  input wire logic [2:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  // Outputs
  input wire logic        dirPinOut,
  input wire logic        dirPinOe,
  input wire logic        countErrorPulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  property p_idle;
    !regRd |=> regRdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data not zero");

  property p_unmap;
    regRd && regAddr > STAT_IDX |=> regRdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");

  property p_resv;
    regRd && regAddr == CTRL_IDX |=> !regRdata[14];
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bit set");

  property p_oe;
    (regWr && regAddr == CTRL_IDX) |-> ##2 dirPinOe == $past(regWdata[DOUT_BIT], 2);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable mismatch");

  property p_sidl;
    (regWr && regAddr == CTRL_IDX) ##2 (regRd && regAddr == CTRL_IDX)
      |=> regRdata[SIDL_BIT] == $past(regWdata[SIDL_BIT], 3);
  endproperty
  a_sidl: assert property (p_sidl)
    else $error("idle bit readback");

  property p_lim;
    (regWr && regAddr == LIMIT_IDX) ##2 (regRd && regAddr == LIMIT_IDX)
      |=> regRdata == $past(regWdata, 3);
  endproperty
  a_lim: assert property (p_lim)
    else $error("limit readback");

  property p_pulse;
    countErrorPulse |=> !countErrorPulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("error pulse too long");

  property p_rst;
    $fell(srst) |-> !dirPinOe && !dirPinOut && !countErrorPulse;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs set after reset");
endmodule

bind quadrature_encoder_interface qei_asserts qei_asserts_i (
  .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .dirPinOut(dirPinOut), .dirPinOe(dirPinOe),
  .countErrorPulse(countErrorPulse)
);

// >>> encoder_model.sv
module encoder_model (
  // Clock
  input  wire logic mclk,
  // Motion commands
  input  wire logic stepUp,
  input  wire logic stepDn,
  input  wire logic glitch,
  input  wire logic idxPulse,
  // Encoder lines
  output logic      phaseA,
  output logic      phaseB,
  output logic      marker
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos_r = 2'h0;

  always_ff @(posedge mclk)
  begin
    if (stepUp)
      pos_r <= pos_r + 2'h1;
    else if (stepDn)
      pos_r <= pos_r - 2'h1;
    else if (glitch)
      pos_r <= pos_r + 2'h2;
  end

  assign phaseA = pos_r[1] ^ pos_r[0];
  assign phaseB = pos_r[1];
  assign marker = idxPulse;
endmodule

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qei_pkg::*;

  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        chipIdle = 1'b0;
  logic        phaseA, phaseB, marker;
  logic        stepUp = 1'b0, stepDn = 1'b0, glitch = 1'b0, idxPulse = 1'b0;
  logic        dirPinOut, dirPinOe, countErrorPulse;
  logic        errSeen = 1'b0;
  logic [15:0] v;
  logic [2:0]  offModes [3] = '{3'h0, 3'h3, 3'h2};
  logic [15:0] noReset [2] = '{16'h0600, 16'h0704};
  int          miscompares = 0;
  int          nTests = 0;
  int          cyc = 0;

  always #4 mclk = ~mclk;

  quadrature_encoder_interface quadrature_encoder_interface_i (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .chipIdle(chipIdle), .phaseAPin(phaseA),
    .phaseBPin(phaseB), .markerPin(marker), .dirPinOut(dirPinOut), .dirPinOe(dirPinOe),
    .countErrorPulse(countErrorPulse)
  );

  encoder_model encoder_model_i (
    .mclk(mclk), .stepUp(stepUp), .stepDn(stepDn), .glitch(glitch),
    .idxPulse(idxPulse), .phaseA(phaseA), .phaseB(phaseB), .marker(marker)
  );

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    nTests++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  task automatic rc(input logic [2:0] a, input logic [15:0] e);
    rd(a);
    chk(v, e);
  endtask

  // Steps spaced well beyond the pin sync latency
  task automatic mv(input int n, input logic up);
    repeat (n)
    begin
      @(posedge mclk);
      stepUp <= up;
      stepDn <= !up;
      @(posedge mclk);
      stepUp <= 1'b0;
      stepDn <= 1'b0;
      repeat (8) @(posedge mclk);
    end
  endtask

  task automatic mark;
    @(posedge mclk);
    idxPulse <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(CTRL_IDX);
    @(posedge mclk);
    idxPulse <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic jolt;
    @(posedge mclk);
    glitch <= 1'b1;
    @(posedge mclk);
    glitch <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic setup(input logic [15:0] c);
    wr(CTRL_IDX, c);
    wr(POS_IDX, 16'h0000);
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (countErrorPulse === 1'b1)
      errSeen = 1'b1;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rc(CTRL_IDX, CTRL_RESET);
    rc(LIMIT_IDX, LIMIT_RESET);
    rc(POS_IDX, 16'h0000);
    wr(3'h6, 16'hFFFF);
    rc(3'h5, 16'h0000);
    rc(CTRL_IDX, CTRL_RESET);
    $display("reset test done");
    wr(LIMIT_IDX, 16'h0005);
    rc(LIMIT_IDX, 16'h0005);
    setup(16'h0759);
    mv(3, 1'b1);
    rc(POS_IDX, 16'h0003);
    rd(CTRL_IDX);
    chk(16'(v[DIR_BIT]), 16'h0001);
    chk(16'({dirPinOe, dirPinOut}), 16'h0003);
    mv(4, 1'b0);
    rc(POS_IDX, 16'h0005);
    rd(CTRL_IDX);
    chk(16'(v[DIR_BIT]), 16'h0000);
    mv(1, 1'b1);
    rc(POS_IDX, 16'h0000);
    $display("x4 test done");
    wr(LIMIT_IDX, 16'hFFFF);
    setup(16'h0500);
    mv(4, 1'b1);
    rc(POS_IDX, 16'h0002);
    for (int i = 0; i < 3; i++)
    begin
      setup({5'h00, offModes[i], 8'h00});
      mv(2, 1'b1);
      rc(POS_IDX, 16'h0000);
    end
    setup(16'h0780);
    mv(1, 1'b1);
    rc(POS_IDX, 16'hFFFF);
    $display("mode test done");
    setup(16'h0604);
    mv(2, 1'b1);
    mark();
    chk(16'(v[MARK_BIT]), 16'h0001);
    rc(POS_IDX, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      setup(noReset[i]);
      mv(2, 1'b1);
      mark();
      rc(POS_IDX, 16'h0002);
    end
    $display("marker test done");
    setup(16'h0600);
    errSeen = 1'b0;
    jolt();
    rd(CTRL_IDX);
    chk(16'(v[ERR_BIT]), 16'h0001);
    rc(POS_IDX, 16'h0000);
    chk(16'(errSeen), 16'h0001);
    setup(16'h0700);
    errSeen = 1'b0;
    jolt();
    rd(CTRL_IDX);
    chk(16'(v[ERR_BIT]), 16'h0000);
    chk(16'(errSeen), 16'h0000);
    $display("error test done");
    @(posedge mclk);
    chipIdle <= 1'b1;
    wr(CTRL_IDX, 16'h2700);
    rd(CTRL_IDX);
    chk(16'(v[SIDL_BIT]), 16'h0001);
    wr(POS_IDX, 16'h0000);
    mv(4, 1'b1);
    rc(POS_IDX, 16'h0000);
    wr(CTRL_IDX, 16'h0700);
    mv(2, 1'b1);
    rc(POS_IDX, 16'h0002);
    @(posedge mclk);
    chipIdle <= 1'b0;
    $display("idle test done");
    wr(CTRL_IDX, 16'h0102);
    setup(16'h0902);
    mv(8, 1'b1);
    rc(POS_IDX, 16'h0002);
    rd(CTRL_IDX);
    chk(16'(v[DIR_BIT]), 16'h0001);
    setup(16'h090A);
    mv(8, 1'b1);
    rc(POS_IDX, 16'h0000);
    mv(24, 1'b1);
    rc(POS_IDX, 16'h0001);
    setup(16'h0903);
    mv(4, 1'b1);
    rc(POS_IDX, 16'hFFFF);
    $display("timer test done");
    setup(16'h0701);
    mv(2, 1'b0);
    rc(POS_IDX, 16'hFFFE);
    chk(16'({dirPinOe, dirPinOut}), 16'h0000);
    wr(FILT_IDX, 16'h00F0);
    rc(FILT_IDX, 16'h00F0);
    mv(1, 1'b1);
    rc(POS_IDX, 16'hFFFE);
    repeat (800) @(posedge mclk);
    rc(POS_IDX, 16'hFFFF);
    rc(STAT_IDX, 16'h0003);
    $display("filter test done");
    test_done();
  end
endmodule
